/* verilog/rerr_pkg.sv */
// Shared constants for the reader error and status register bank.
// Assumes an 8-bit register port with a 6-bit address, one clock domain.
package rerr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] RERR_ERROR_FLAGS_ADDR     = 6'h0a;
    localparam logic [5:0] RERR_FIRST_COLL_ADDR      = 6'h0b;
    localparam logic [5:0] RERR_COUNTDOWN_ADDR       = 6'h0c;
    localparam logic [5:0] RERR_CHECKSUM_LOW_ADDR    = 6'h0d;

    // ------------------------------------------------------------------
    // Error flag bit positions and reset values
    // ------------------------------------------------------------------
    localparam int RERR_KEY_BIT      = 6;
    localparam int RERR_NVM_BIT      = 5;
    localparam int RERR_OVFL_BIT     = 4;
    localparam int RERR_CRC_BIT      = 3;
    localparam int RERR_FRAME_BIT    = 2;
    localparam int RERR_PARITY_BIT   = 1;
    localparam int RERR_COLL_BIT     = 0;

    localparam logic [7:0] RERR_ERROR_FLAGS_RESET = 8'h40;
    localparam logic [7:0] RERR_FIRST_COLL_RESET  = 8'h00;
    localparam logic [7:0] RERR_READ_IDLE_VALUE   = 8'h00;

    // Receive sequencing states seen by the collision tracker.
    typedef enum logic [1:0] {
        RERR_RX_IDLE   = 2'b01,
        RERR_RX_ACTIVE = 2'b10
    } rerr_rx_state_type;

endpackage

/* verilog/rerr_sync2.sv */
// Two-flip-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs come from pins outside the core_clk domain.
`timescale 1ns/1ps
module rerr_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_q;

    // A vector of no bits cannot be synchronised, so refuse it early.
    if (WIDTH < 1) begin : g_bad_width
        $error("rerr_sync2 needs a WIDTH of at least one");
    end

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

/* verilog/rerr_collision_tracker.sv */
// Captures the index of the first collided bit in a received frame.
// Assumes bit strobes from the receiver arrive in the core_clk domain.
`timescale 1ns/1ps
module rerr_collision_tracker
    import rerr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       receivePrepare,
    input  wire logic       collisionSeen,
    input  wire logic [7:0] collisionBitIndex,
    output logic      [7:0] firstCollisionIndex
);

    // ------------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------------
    rerr_rx_state_type state_q;

    // Only the first collision in a frame is kept; later ones are ignored
    // so that software learns where the anticollision split must happen.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q             <= RERR_RX_IDLE;
            firstCollisionIndex <= RERR_FIRST_COLL_RESET;
        end else begin
            case (state_q)
                RERR_RX_IDLE: begin
                    if (collisionSeen && !receivePrepare) begin
                        firstCollisionIndex <= collisionBitIndex;
                        state_q             <= RERR_RX_ACTIVE;
                    end
                end
                RERR_RX_ACTIVE: begin
                    if (receivePrepare) begin
                        state_q <= RERR_RX_IDLE;
                    end
                end
                default: begin
                    state_q <= RERR_RX_IDLE;
                end
            endcase
        end
    end

endmodule

/* verilog/reader_error_status_regs.sv */
// Read-only error flag and result register bank of the reader core.
// Assumes event pulses from the command, receiver and queue logic on
// core_clk, and a host register port already synchronised by the port.
// Notes on behaviour
// - Key encoding error sets bit six.
// - Starting either key load clears bit six.
// - Memory permission violation sets bit five.
// - Any memory command start clears bit five.
// - Writing a full queue sets bit four.
// - Failed receive checksum with checking sets bit three.
// - Receive preparation clears receive error bits.
// - Bad start of frame sets bit two.
// - Parity failure sets bit one.
// - Bit collision sets bit zero.
// - First collided bit index is reported.
// - Countdown value readable at 0Ch.
// - Checksum low byte at 0Dh, valid when done.
// - Flags at 0Ah reset 40h, bit seven zero.
// - Queue clear strobe clears overflow flag.
`timescale 1ns/1ps
module reader_error_status_regs
    import rerr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Host register port.
    input  wire logic [5:0] hostAddr,
    input  wire logic       hostRead,
    input  wire logic       hostWrite,
    input  wire logic [7:0] hostWriteData,
    output logic      [7:0] hostReadData,
    output logic            hostReadValid,
    // Command events.
    input  wire logic       keyLoadStart,
    input  wire logic       keyFormatBad,
    input  wire logic       nvmCommandStart,
    input  wire logic       nvmAccessBad,
    // Queue events.
    input  wire logic       queueWriteAttempt,
    input  wire logic       queueFull,
    input  wire logic       queue_clear_strobe,
    // Receiver events.
    input  wire logic       receive_prepare_state,
    input  wire logic       receive_checksum_check_on,
    input  wire logic       checksumFail,
    input  wire logic       frameStartBad,
    input  wire logic       parityFail,
    input  wire logic       collisionSeen,
    input  wire logic [7:0] collisionBitIndex,
    // Timer and checksum unit results.
    input  wire logic [7:0] countdownValue,
    input  wire logic [7:0] checksumResultLow,
    input  wire logic       checksumDoneAsync,
    // Flag image for the rest of the core.
    output logic      [7:0] errorFlags,
    output logic            checksum_done
);

    // ------------------------------------------------------------------
    // Error flag register
    // ------------------------------------------------------------------
    logic       key_format_fault_q;
    logic       nvm_permission_fault_q;
    logic       queue_overflow_flag_q;
    logic       checksum_mismatch_q;
    logic       start_of_frame_fault_q;
    logic       odd_parity_fault_q;
    logic       bit_collision_flag_q;
    logic [7:0] flags_d;
    logic       overflowEvent;

    // A write into a full queue from any writer counts as overflow.
    assign overflowEvent = queueWriteAttempt && queueFull;

    // Key flag: the set wins over the start clear, so an encoding fault
    // flagged in the command's first cycle is never lost.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            key_format_fault_q <= RERR_ERROR_FLAGS_RESET[RERR_KEY_BIT];
        end else if (keyFormatBad) begin
            key_format_fault_q <= 1'b1;
        end else if (keyLoadStart) begin
            key_format_fault_q <= 1'b0;
        end
    end

    // Memory permission flag.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            nvm_permission_fault_q <= RERR_ERROR_FLAGS_RESET[RERR_NVM_BIT];
        end else if (nvmAccessBad) begin
            nvm_permission_fault_q <= 1'b1;
        end else if (nvmCommandStart) begin
            nvm_permission_fault_q <= 1'b0;
        end
    end

    // Overflow flag; cleared only by the queue clear strobe.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            queue_overflow_flag_q <= RERR_ERROR_FLAGS_RESET[RERR_OVFL_BIT];
        end else if (overflowEvent) begin
            queue_overflow_flag_q <= 1'b1;
        end else if (queue_clear_strobe) begin
            queue_overflow_flag_q <= 1'b0;
        end
    end

    // Receive error flags all clear in receive preparation; an error
    // reported in that same cycle still sets its flag.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            checksum_mismatch_q    <= RERR_ERROR_FLAGS_RESET[RERR_CRC_BIT];
            start_of_frame_fault_q <= RERR_ERROR_FLAGS_RESET[RERR_FRAME_BIT];
            odd_parity_fault_q     <= RERR_ERROR_FLAGS_RESET[RERR_PARITY_BIT];
            bit_collision_flag_q   <= RERR_ERROR_FLAGS_RESET[RERR_COLL_BIT];
        end else begin
            if (receive_checksum_check_on && checksumFail) begin
                checksum_mismatch_q <= 1'b1;
            end else if (receive_prepare_state) begin
                checksum_mismatch_q <= 1'b0;
            end
            if (frameStartBad) begin
                start_of_frame_fault_q <= 1'b1;
            end else if (receive_prepare_state) begin
                start_of_frame_fault_q <= 1'b0;
            end
            if (parityFail) begin
                odd_parity_fault_q <= 1'b1;
            end else if (receive_prepare_state) begin
                odd_parity_fault_q <= 1'b0;
            end
            if (collisionSeen) begin
                bit_collision_flag_q <= 1'b1;
            end else if (receive_prepare_state) begin
                bit_collision_flag_q <= 1'b0;
            end
        end
    end

    // Assemble the flag byte; bit seven is reserved and reads zero.
    always_comb begin
        flags_d                  = 8'h00;
        flags_d[RERR_KEY_BIT]    = key_format_fault_q;
        flags_d[RERR_NVM_BIT]    = nvm_permission_fault_q;
        flags_d[RERR_OVFL_BIT]   = queue_overflow_flag_q;
        flags_d[RERR_CRC_BIT]    = checksum_mismatch_q;
        flags_d[RERR_FRAME_BIT]  = start_of_frame_fault_q;
        flags_d[RERR_PARITY_BIT] = odd_parity_fault_q;
        flags_d[RERR_COLL_BIT]   = bit_collision_flag_q;
    end

    // Registered copy for the rest of the core, one cycle behind.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            errorFlags <= RERR_ERROR_FLAGS_RESET;
        end else begin
            errorFlags <= flags_d;
        end
    end

    // ------------------------------------------------------------------
    // Collision index and checksum ready
    // ------------------------------------------------------------------
    logic [7:0] first_collision_index;
    logic       checksumDoneSync;

    rerr_collision_tracker u_collision (
        .core_clk            (core_clk),
        .reset               (reset),
        .receivePrepare      (receive_prepare_state),
        .collisionSeen       (collisionSeen),
        .collisionBitIndex   (collisionBitIndex),
        .firstCollisionIndex (first_collision_index)
    );

    // The done level comes from the checksum unit's own clock in some
    // builds, so it is synchronised here regardless.
    rerr_sync2 #(
        .WIDTH (1)
    ) u_done_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .asyncIn  (checksumDoneAsync),
        .syncOut  (checksumDoneSync)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            checksum_done <= 1'b0;
        end else begin
            checksum_done <= checksumDoneSync;
        end
    end

    // ------------------------------------------------------------------
    // Host read path
    // ------------------------------------------------------------------
    logic [7:0] readMux;

    // Address decode; unmapped offsets read as zero.
    always_comb begin
        if (hostAddr == RERR_ERROR_FLAGS_ADDR) begin
            readMux = flags_d;
        end else if (hostAddr == RERR_FIRST_COLL_ADDR) begin
            readMux = first_collision_index;
        end else if (hostAddr == RERR_COUNTDOWN_ADDR) begin
            readMux = countdownValue;
        end else if (hostAddr == RERR_CHECKSUM_LOW_ADDR) begin
            readMux = checksumResultLow;
        end else begin
            readMux = RERR_READ_IDLE_VALUE;
        end
    end

    // Read data is registered one cycle after the strobe. Writes have no
    // path into any register here, so they are simply dropped.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hostReadData  <= RERR_READ_IDLE_VALUE;
            hostReadValid <= 1'b0;
        end else begin
            hostReadValid <= hostRead && !hostWrite;
            if (hostRead && !hostWrite) begin
                hostReadData <= readMux;
            end
        end
    end

    // Write data is intentionally unused: every register here is RO.
    logic unusedWrite;
    assign unusedWrite = ^hostWriteData;

endmodule

/* tb/rerr_chk.sv */
// Port assertions for the reader status register bank.
// Assumes it is bound to the top module; one clock, synchronous reset.
`timescale 1ns/1ps
module rerr_chk (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic [5:0] hostAddr,
    input wire logic       hostRead,
    input wire logic       hostWrite,
    input wire logic [7:0] hostReadData,
    input wire logic       hostReadValid,
    input wire logic       keyLoadStart,
    input wire logic       keyFormatBad,
    input wire logic       nvmCommandStart,
    input wire logic       nvmAccessBad,
    input wire logic       queueWriteAttempt,
    input wire logic       queueFull,
    input wire logic       queue_clear_strobe,
    input wire logic       receive_prepare_state,
    input wire logic       checksumFail,
    input wire logic       frameStartBad,
    input wire logic       parityFail,
    input wire logic       collisionSeen,
    input wire logic [7:0] countdownValue,
    input wire logic [7:0] errorFlags
);
    // ------------------------------------------------------------------
    // Relations between events and the flag image
    // ------------------------------------------------------------------
    // The flag image lags an event by two edges, so each set or clear
    // is checked exactly two cycles on.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    read_answer_a: assert property (hostRead && !hostWrite |=> hostReadValid)
        else $error("read not answered next cycle");
    read_quiet_a: assert property (
        !hostRead || hostWrite |=> !hostReadValid)
        else $error("read valid without a read");
    key_set_a: assert property (keyFormatBad |-> ##2 errorFlags[6])
        else $error("key fault not raised");
    key_clear_a: assert property (
        keyLoadStart && !keyFormatBad |-> ##2 !errorFlags[6])
        else $error("key fault not cleared");
    nvm_set_a: assert property (nvmAccessBad |-> ##2 errorFlags[5])
        else $error("permission fault not raised");
    nvm_clear_a: assert property (
        nvmCommandStart && !nvmAccessBad |-> ##2 !errorFlags[5])
        else $error("permission fault not cleared");
    ovfl_set_a: assert property (
        queueWriteAttempt && queueFull |-> ##2 errorFlags[4])
        else $error("overflow not raised");
    ovfl_clear_a: assert property (
        queue_clear_strobe && !queueWriteAttempt |-> ##2 !errorFlags[4])
        else $error("overflow not cleared");
    rx_clear_a: assert property (receive_prepare_state && !checksumFail
        && !frameStartBad && !parityFail && !collisionSeen
        |-> ##2 errorFlags[3:0] == 4'h0) else $error("rx flags not cleared");
    frame_set_a: assert property (frameStartBad |-> ##2 errorFlags[2])
        else $error("frame fault not raised");
    parity_set_a: assert property (parityFail |-> ##2 errorFlags[1])
        else $error("parity fault not raised");
    coll_set_a: assert property (collisionSeen |-> ##2 errorFlags[0])
        else $error("collision not raised");
    timer_read_a: assert property (hostRead && !hostWrite
        && hostAddr == 6'h0c |=> hostReadData == $past(countdownValue))
        else $error("countdown read wrong");
    top_bit_a: assert property (errorFlags[7] == 1'b0)
        else $error("reserved flag bit set");
endmodule

bind reader_error_status_regs rerr_chk chk_u (
    .core_clk, .reset, .hostAddr, .hostRead, .hostWrite, .hostReadData,
    .hostReadValid, .keyLoadStart, .keyFormatBad, .nvmCommandStart,
    .nvmAccessBad, .queueWriteAttempt, .queueFull, .queue_clear_strobe,
    .receive_prepare_state, .checksumFail, .frameStartBad, .parityFail,
    .collisionSeen, .countdownValue, .errorFlags
);

/* tb/reader_error_status_regs_tb.sv */
// Self-checking bench for the reader status register bank.
// Assumes package and design compiled first; 25 MHz clock, sync reset.
`timescale 1ns/1ps
module reader_error_status_regs_tb
    import rerr_pkg::*;
;
    logic       core_clk, reset, hostRead, hostWrite, queueFull;
    logic       prepOn, crcOn, doneAsync, hostReadValid, checksum_done;
    logic [5:0] hostAddr;
    logic [7:0] wData, cIdx, cntVal, crcLow, hostReadData, errorFlags;
    logic [9:0] ev;
    int         n_mismatch, check_count;

    reader_error_status_regs dut_u (.core_clk, .reset, .hostAddr,
        .hostRead, .hostWrite, .hostWriteData(wData), .hostReadData,
        .hostReadValid, .keyLoadStart(ev[0]), .keyFormatBad(ev[1]),
        .nvmCommandStart(ev[2]), .nvmAccessBad(ev[3]),
        .queueWriteAttempt(ev[4]), .queueFull, .queue_clear_strobe(ev[5]),
        .receive_prepare_state(prepOn), .receive_checksum_check_on(crcOn),
        .checksumFail(ev[6]), .frameStartBad(ev[7]), .parityFail(ev[8]),
        .collisionSeen(ev[9]), .collisionBitIndex(cIdx),
        .countdownValue(cntVal), .checksumResultLow(crcLow),
        .checksumDoneAsync(doneAsync), .errorFlags, .checksum_done);

    // 40 ns period; the half period flips the clock.
    always #20 core_clk = ~core_clk;

    task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A read is answered one edge later; sampled 1 ns after to avoid races.
    task automatic rd(logic [5:0] a, logic [7:0] exp);
        @(posedge core_clk);
        hostAddr <= a;
        hostRead <= 1'b1;
        @(posedge core_clk);
        hostRead <= 1'b0;
        #1;
        chk("valid", {7'h00, hostReadValid}, 8'h01);
        chk("rdata", hostReadData, exp);
    endtask

    task automatic pulse(logic [9:0] m);
        @(posedge core_clk);
        ev <= m;
        @(posedge core_clk);
        ev <= '0;
    endtask

    task automatic prepare;
        @(posedge core_clk);
        prepOn <= 1'b1;
        @(posedge core_clk);
        prepOn <= 1'b0;
    endtask

    task automatic t_reset;
        rd(RERR_ERROR_FLAGS_ADDR, 8'h40);
        rd(RERR_FIRST_COLL_ADDR, 8'h00);
        chk("image", errorFlags, 8'h40);
    endtask

    task automatic t_cmds;
        pulse(10'h001);
        rd(RERR_ERROR_FLAGS_ADDR, 8'h00);
        pulse(10'h002);
        rd(RERR_ERROR_FLAGS_ADDR, 8'h40);
        pulse(10'h008);
        rd(RERR_ERROR_FLAGS_ADDR, 8'h60);
        pulse(10'h004);
        rd(RERR_ERROR_FLAGS_ADDR, 8'h40);
    endtask

    // A write attempt only counts as overflow while the queue is full.
    task automatic t_queue;
        pulse(10'h010);
        rd(RERR_ERROR_FLAGS_ADDR, 8'h40);
        @(posedge core_clk);
        queueFull <= 1'b1;
        pulse(10'h010);
        rd(RERR_ERROR_FLAGS_ADDR, 8'h50);
        pulse(10'h020);
        rd(RERR_ERROR_FLAGS_ADDR, 8'h40);
    endtask

    task automatic t_rx;
        prepare();
        pulse(10'h040);
        rd(RERR_ERROR_FLAGS_ADDR, 8'h40);
        @(posedge core_clk);
        crcOn <= 1'b1;
        cIdx <= 8'h05;
        pulse(10'h3c0);
        rd(RERR_ERROR_FLAGS_ADDR, 8'h4f);
        rd(RERR_FIRST_COLL_ADDR, 8'h05);
        @(posedge core_clk);
        cIdx <= 8'h07;
        pulse(10'h200);
        rd(RERR_FIRST_COLL_ADDR, 8'h05);
        prepare();
        rd(RERR_ERROR_FLAGS_ADDR, 8'h40);
        @(posedge core_clk);
        cIdx <= 8'h08;
        pulse(10'h200);
        rd(RERR_FIRST_COLL_ADDR, 8'h08);
    endtask

    task automatic t_results;
        @(posedge core_clk);
        cntVal <= 8'h3c;
        crcLow <= 8'ha5;
        doneAsync <= 1'b1;
        rd(RERR_COUNTDOWN_ADDR, 8'h3c);
        repeat (2) @(posedge core_clk);
        #1;
        chk("done", {7'h00, checksum_done}, 8'h01);
        rd(RERR_CHECKSUM_LOW_ADDR, 8'ha5);
    endtask

    // Writes must be dropped; an unmapped read returns the idle value.
    task automatic t_write;
        @(posedge core_clk);
        hostAddr <= RERR_ERROR_FLAGS_ADDR;
        hostWrite <= 1'b1;
        wData <= 8'hff;
        @(posedge core_clk);
        hostAddr <= RERR_FIRST_COLL_ADDR;
        @(posedge core_clk);
        hostWrite <= 1'b0;
        // The last collision of the receive scenario left bit zero set.
        rd(RERR_ERROR_FLAGS_ADDR, 8'h41);
        rd(RERR_FIRST_COLL_ADDR, 8'h08);
        rd(6'h3f, RERR_READ_IDLE_VALUE);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Reset for 12 cycles, then run every scenario in turn.
    initial begin
        {core_clk, hostRead, hostWrite, queueFull, prepOn, crcOn} = '0;
        {doneAsync, hostAddr, wData, cIdx, cntVal, crcLow, ev} = '0;
        reset = 1'b1;
        n_mismatch = 0;
        check_count = 0;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_cmds();
        t_queue();
        t_rx();
        t_results();
        t_write();
        report_and_stop();
    end
endmodule
